// >>> pmc_adc_ctrl.sv
/*
 * Measurement control and result registers of a power monitor, with an APB register slave.
 * Assumes converter samples are valid whenever a conversion period ends.
 */
// The APB slave port is this design's own decision.
// What this block does
// RL1: Mode field bits 15-12 resets to Fh; codes 0h and 8h shut down.
// RL2: Codes 1h,4h,5h,6h,7h run one triggered sequence of the listed channels.
// RL3: Codes 9h,Ch,Dh,Fh convert the listed channels continuously.
// RL4: Software never writes reserved mode codes 2h, 3h, Ah or Bh.
// RL5: Bits 11-9, reset 5h, pick bus conversion time from 50 to 4120 us.
// RL6: Bits 8-6, reset 5h, pick shunt conversion time from the same table.
// RL7: A current measurement lasts shunt time plus temperature time.
// RL8: Bits 5-3, reset 5h, pick temperature conversion time from the same table.
// RL9: Bits 2-0, reset 0h, pick 1 to 1024 averaged samples.
// RL10: One averaging count applies to every active channel.
// RL11: With averaging, results update only after the whole run.
// RL12: Bus result is 16-bit two's complement, 3.125 mV per step, resets zero.
// RL13: Temperature sits in bits 15-4, 125 mC per step; bits 3-0 read zero.
// RL14: Current result is 16-bit two's complement, 1.2 mA per step, resets zero.
// RL15: Power result is 24-bit unsigned, 240 uW per step.
// RL16: An 8-bit delay in 2 ms steps precedes the first conversion.
// RL17: A ready flag sets each time a conversion cycle completes.
// RL18: A triggered mode write runs one sequence, then the converter idles.
// RL19: Undocumented code Eh acts as shutdown, like other reserved codes.
`include "pmc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pmc_adc_ctrl #(
	parameter int unsigned CYC_PER_US = `PMC_CLK_MHZ
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Converter samples
	input  wire logic [15:0] bus_sample,
	input  wire logic [15:0] current_sample,
	input  wire logic [11:0] temp_sample,
	// Converter status
	output logic      [2:0]  chan_sel,
	output logic             conv_ready
);

	pmc_pkg::pmc_state_rec_t s_r;
	pmc_pkg::pmc_state_rec_t s_nxt;
	logic                    tmr_done;

	pmc_conv_timer u_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (s_r.tld),
		.load_val (s_r.tval),
		.done     (tmr_done)
	);

	// Address to register
	function automatic pmc_pkg::pmc_reg_t reg_sel(input logic [7:0] a);
		if (a[1:0] != 2'b00) begin
			return pmc_pkg::R_NONE;
		end
		case (a[7:2])
			`PMC_IDX_START:  return pmc_pkg::R_START;
			`PMC_IDX_SETUP:  return pmc_pkg::R_SETUP;
			`PMC_IDX_STATUS: return pmc_pkg::R_STATUS;
			`PMC_IDX_BUS:    return pmc_pkg::R_BUS;
			`PMC_IDX_TEMP:   return pmc_pkg::R_TEMP;
			`PMC_IDX_CURR:   return pmc_pkg::R_CURR;
			`PMC_IDX_POWER:  return pmc_pkg::R_POWER;
			default:         return pmc_pkg::R_NONE;
		endcase
	endfunction

	// Mode to {continuous, temp, current, bus}; reserved codes shut down
	function automatic logic [3:0] mode_chans(input logic [3:0] m);
		case (m)
			4'h1:    return 4'b0001; // RL2
			4'h4:    return 4'b0100; // RL2
			4'h5:    return 4'b0101; // RL2
			4'h6:    return 4'b0110; // RL2
			4'h7:    return 4'b0111; // RL2
			4'h9:    return 4'b1001; // RL3
			4'hc:    return 4'b1100; // RL3
			4'hd:    return 4'b1110; // RL3
			4'hf:    return 4'b1111; // RL3
			default: return 4'b0000; // RL1 RL4 RL19
		endcase
	endfunction

	// Conversion time code to cycles
	function automatic logic [31:0] conv_cycles(input logic [2:0] c);
		int unsigned us;
		us = `PMC_CT_US_0;
		case (c)
			3'h0:    us = `PMC_CT_US_0;
			3'h1:    us = `PMC_CT_US_1;
			3'h2:    us = `PMC_CT_US_2;
			3'h3:    us = `PMC_CT_US_3;
			3'h4:    us = `PMC_CT_US_4;
			3'h5:    us = `PMC_CT_US_5;
			3'h6:    us = `PMC_CT_US_6;
			default: us = `PMC_CT_US_7;
		endcase
		return 32'(us * CYC_PER_US);
	endfunction

	// Averaging code to log2 of sample count
	function automatic logic [3:0] avg_shift(input logic [2:0] c);
		case (c)
			3'h0:    return 4'h0;
			3'h1:    return 4'h2;
			3'h2:    return 4'h4;
			3'h3:    return 4'h6;
			3'h4:    return 4'h7;
			3'h5:    return 4'h8;
			3'h6:    return 4'h9;
			default: return 4'ha;
		endcase
	endfunction

	// Next enabled channel after position pos (0 start, 1 temp, 2 current)
	function automatic pmc_pkg::pmc_state_t next_chan(input logic [1:0] pos,
			input logic [2:0] en);
		if (pos == 2'd0 && en[2]) begin
			return pmc_pkg::S_TEMP;
		end
		if (pos <= 2'd1 && en[1]) begin
			return pmc_pkg::S_CURR;
		end
		if (pos <= 2'd2 && en[0]) begin
			return pmc_pkg::S_BUS;
		end
		return pmc_pkg::S_STORE;
	endfunction

	always_comb begin
		pmc_pkg::pmc_reg_t    sel;
		pmc_pkg::pmc_state_t  after;
		logic [3:0]           chans;
		logic [3:0]           sh;
		logic [10:0]          rounds;
		logic                 setup_ph;
		logic                 acc_wr;
		logic                 acc_rd;
		logic [1:0]           pos;
		logic signed [27:0]   avg_b;
		logic signed [27:0]   avg_t;
		logic signed [27:0]   avg_c;
		logic [15:0]          cur_abs;
		logic [31:0]          prod;
		logic [25:0]          pwr;

		s_nxt    = s_r;
		sel      = reg_sel(paddr);
		chans    = mode_chans(s_r.setup[`PMC_MODE_HI:`PMC_MODE_LO]);
		sh       = avg_shift(s_r.setup[`PMC_NSMP_HI:`PMC_NSMP_LO]); // RL9 RL10
		rounds   = 11'((32'h0000_0001 << sh) - 32'h0000_0001);
		setup_ph = psel && !penable;
		acc_wr   = psel && penable && s_r.pready && pwrite;
		acc_rd   = psel && penable && s_r.pready && !pwrite;
		after    = pmc_pkg::S_STORE;
		pos      = 2'd0;
		avg_b    = $signed(s_r.acc_bus) >>> sh;
		avg_t    = $signed(s_r.acc_tmp) >>> sh;
		avg_c    = $signed(s_r.acc_cur) >>> sh;
		cur_abs  = s_r.cur_res[15] ? 16'((~s_r.cur_res) + 16'h0001) : s_r.cur_res;
		prod     = 32'(s_r.bus_res) * 32'(cur_abs);
		pwr      = prod[31:`PMC_PWR_SHIFT];
		s_nxt.tld = 1'b0;

		// Sequencer
		case (s_r.st)
			pmc_pkg::S_IDLE: begin
				s_nxt.chan = 3'b000;
			end
			pmc_pkg::S_DELAY: begin
				if (s_r.dly == 8'h00) begin
					s_nxt.st = next_chan(2'd0, chans[2:0]); // RL16
				end else if (!s_r.armed) begin
					s_nxt.armed = 1'b1;
					s_nxt.tld   = 1'b1;
					s_nxt.tval  = 32'(32'(s_r.dly) * `PMC_DLY_STEP_US * CYC_PER_US); // RL16
				end else if (tmr_done && !s_r.tld) begin
					s_nxt.armed = 1'b0;
					s_nxt.st    = next_chan(2'd0, chans[2:0]);
				end
			end
			pmc_pkg::S_TEMP, pmc_pkg::S_CURR, pmc_pkg::S_BUS: begin
				if (!s_r.armed) begin
					s_nxt.armed = 1'b1;
					s_nxt.tld   = 1'b1;
					if (s_r.st == pmc_pkg::S_TEMP) begin
						s_nxt.chan = 3'b100;
						s_nxt.tval = conv_cycles(s_r.setup[`PMC_TMPT_HI:`PMC_TMPT_LO]); // RL8
					end else if (s_r.st == pmc_pkg::S_CURR) begin
						s_nxt.chan = 3'b010;
						s_nxt.tval = conv_cycles(s_r.setup[`PMC_SCT_HI:`PMC_SCT_LO])
							+ conv_cycles(s_r.setup[`PMC_TMPT_HI:`PMC_TMPT_LO]); // RL6 RL7
					end else begin
						s_nxt.chan = 3'b001;
						s_nxt.tval = conv_cycles(s_r.setup[`PMC_BCT_HI:`PMC_BCT_LO]); // RL5
					end
				end else if (tmr_done && !s_r.tld) begin
					// A stale expiry from an abandoned run must not end a fresh one
					s_nxt.armed = 1'b0;
					if (s_r.st == pmc_pkg::S_TEMP) begin
						pos           = 2'd1;
						s_nxt.acc_tmp = s_r.acc_tmp + {{16{temp_sample[11]}}, temp_sample};
					end else if (s_r.st == pmc_pkg::S_CURR) begin
						pos           = 2'd2;
						s_nxt.acc_cur = s_r.acc_cur
							+ {{12{current_sample[15]}}, current_sample};
					end else begin
						pos           = 2'd3;
						s_nxt.acc_bus = s_r.acc_bus + {{12{bus_sample[15]}}, bus_sample};
					end
					after = next_chan(pos, chans[2:0]);
					if (after != pmc_pkg::S_STORE) begin
						s_nxt.st = after;
					end else if (s_r.rnd != rounds) begin
						s_nxt.rnd = s_r.rnd + 11'h001; // RL11
						s_nxt.st  = next_chan(2'd0, chans[2:0]);
					end else begin
						s_nxt.st = pmc_pkg::S_STORE;
					end
				end
			end
			pmc_pkg::S_STORE: begin
				s_nxt.chan = 3'b000;
				if (chans[0]) begin
					s_nxt.bus_res = avg_b[15:0]; // RL11 RL12
				end
				if (chans[2]) begin
					s_nxt.tmp_res = avg_t[11:0]; // RL11 RL13
				end
				if (chans[1]) begin
					s_nxt.cur_res = avg_c[15:0]; // RL11 RL14
				end
				s_nxt.acc_bus = '0;
				s_nxt.acc_tmp = '0;
				s_nxt.acc_cur = '0;
				s_nxt.rnd     = '0;
				s_nxt.st      = pmc_pkg::S_PWR;
			end
			pmc_pkg::S_PWR: begin
				s_nxt.pwr_res = (pwr[25:24] != 2'b00) ? 24'hff_ffff : pwr[23:0]; // RL15
				s_nxt.ready   = 1'b1; // RL17
				if (chans[3]) begin
					s_nxt.st = next_chan(2'd0, chans[2:0]); // RL3
				end else begin
					s_nxt.st = pmc_pkg::S_IDLE; // RL18
				end
			end
			default: begin
				s_nxt.st = pmc_pkg::S_IDLE;
			end
		endcase

		// Status read clears ready; a completion in the same cycle wins
		if (acc_rd && sel == pmc_pkg::R_STATUS && s_r.st != pmc_pkg::S_PWR) begin
			s_nxt.ready = 1'b0; // RL17
		end

		// Register writes
		if (acc_wr) begin
			case (sel)
				pmc_pkg::R_START: begin
					s_nxt.dly = pwdata[`PMC_DLY_HI:`PMC_DLY_LO]; // RL16
				end
				pmc_pkg::R_SETUP: begin
					s_nxt.setup   = pwdata[15:0];
					s_nxt.armed   = 1'b0;
					s_nxt.rnd     = '0;
					s_nxt.acc_bus = '0;
					s_nxt.acc_tmp = '0;
					s_nxt.acc_cur = '0;
					s_nxt.chan    = 3'b000;
					if (mode_chans(pwdata[`PMC_MODE_HI:`PMC_MODE_LO]) != 4'b0000) begin
						s_nxt.st = pmc_pkg::S_DELAY; // RL18
					end else begin
						s_nxt.st = pmc_pkg::S_IDLE; // RL1
					end
				end
				default: begin
				end
			endcase
		end

		// APB answer, zero wait states
		s_nxt.pready  = setup_ph;
		s_nxt.pslverr = setup_ph && sel == pmc_pkg::R_NONE;
		s_nxt.prdata  = 32'h0000_0000;
		if (setup_ph && !pwrite) begin
			case (sel)
				pmc_pkg::R_START: begin
					s_nxt.prdata[`PMC_DLY_HI:`PMC_DLY_LO] = s_r.dly;
				end
				pmc_pkg::R_SETUP:  s_nxt.prdata[15:0] = s_r.setup;
				pmc_pkg::R_STATUS: begin
					s_nxt.prdata[`PMC_ST_READY] = s_r.ready;
					s_nxt.prdata[`PMC_ST_BUSY]  = s_r.st != pmc_pkg::S_IDLE;
				end
				pmc_pkg::R_BUS:    s_nxt.prdata[15:0] = s_r.bus_res;
				pmc_pkg::R_TEMP:   s_nxt.prdata[15:0] = {s_r.tmp_res, 4'h0}; // RL13
				pmc_pkg::R_CURR:   s_nxt.prdata[15:0] = s_r.cur_res;
				pmc_pkg::R_POWER:  s_nxt.prdata[23:0] = s_r.pwr_res;
				default:           s_nxt.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r       <= '0;
			s_r.st    <= pmc_pkg::S_DELAY;
			s_r.setup <= `PMC_SETUP_RST; // RL1 RL5 RL6 RL8 RL9
			s_r.dly   <= `PMC_DLY_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata     = s_r.prdata;
	assign pready     = s_r.pready;
	assign pslverr    = s_r.pslverr;
	assign chan_sel   = s_r.chan;
	assign conv_ready = s_r.ready;

endmodule // pmc_adc_ctrl

`default_nettype wire

// >>> pmc_adc_ctrl_properties.sv
/*
 * Port checker for the converter control block.
 * Assumes it is bound onto pmc_adc_ctrl, with one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module pmc_adc_ctrl_chk #(
	parameter int unsigned CYC_PER_US = 1
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Converter status
	input wire logic [2:0]  chan_sel,
	input wire logic        conv_ready
);
	logic [3:0] mode_r;
	logic [2:0] age_r;
	logic       st_rd;

	// Status read in its access cycle
	assign st_rd = psel && penable && pready && !pwrite && paddr == 8'h08;

	// Mode last written and cycles since
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= 4'hf;
			age_r  <= 3'h7;
		end else if (psel && penable && pready && pwrite && paddr == 8'h04) begin
			mode_r <= pwdata[15:12];
			age_r  <= 3'h0;
		end else if (age_r != 3'h7) begin
			age_r <= age_r + 3'h1;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_APB_ANSWER: assert property ((psel && !penable) |=> pready)
		else $error("no ready after setup");
	AST_APB_ONE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_APB_MAP: assert property ((psel && !penable) |=>
		(pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h1c, 8'h20})))
		else $error("error response wrong for address");
	AST_SHUTDOWN_IDLE: assert property (
		(mode_r inside {4'h0, 4'h2, 4'h3, 4'h8, 4'ha, 4'hb, 4'he} && age_r >= 3'h3)
		|-> chan_sel == 3'h0) else $error("conversion while shut down");
	AST_SETUP_UPPER: assert property (
		(pready && !pwrite && paddr == 8'h04) |-> prdata[31:16] == 16'h0000)
		else $error("setup upper bits set");
	AST_BUS_UPPER: assert property (
		(pready && !pwrite && paddr == 8'h14) |-> prdata[31:16] == 16'h0000)
		else $error("bus result upper bits set");
	AST_TEMP_LOW: assert property (
		(pready && !pwrite && paddr == 8'h18) |-> prdata[3:0] == 4'h0 && prdata[31:16] == 16'h0000)
		else $error("temperature low bits set");
	AST_CURR_UPPER: assert property (
		(pready && !pwrite && paddr == 8'h1c) |-> prdata[31:16] == 16'h0000)
		else $error("current upper bits set");
	AST_PWR_UPPER: assert property (
		(pready && !pwrite && paddr == 8'h20) |-> prdata[31:24] == 8'h00)
		else $error("power upper bits set");
	AST_ONE_CHANNEL: assert property ($onehot0(chan_sel))
		else $error("two channels at once");
	AST_READY_CLEAR: assert property ($fell(conv_ready) |-> $past(st_rd))
		else $error("ready dropped without status read");

endmodule // pmc_adc_ctrl_chk

bind pmc_adc_ctrl pmc_adc_ctrl_chk #(.CYC_PER_US(CYC_PER_US)) u_pmc_adc_ctrl_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.chan_sel(chan_sel), .conv_ready(conv_ready));

`default_nettype wire

// >>> pmc_consts.svh
/*
 * Offsets, field positions, reset values and timing figures of the converter control block.
 * Assumes a 250 MHz register clock and register indices that become byte addresses times four.
 */
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// Register indices, byte address is four times the index
`define PMC_IDX_START     6'h00
`define PMC_IDX_SETUP     6'h01
`define PMC_IDX_STATUS    6'h02
`define PMC_IDX_BUS       6'h05
`define PMC_IDX_TEMP      6'h06
`define PMC_IDX_CURR      6'h07
`define PMC_IDX_POWER     6'h08

// Converter setup fields
`define PMC_MODE_HI       15
`define PMC_MODE_LO       12
`define PMC_BCT_HI        11
`define PMC_BCT_LO        9
`define PMC_SCT_HI        8
`define PMC_SCT_LO        6
`define PMC_TMPT_HI       5
`define PMC_TMPT_LO       3
`define PMC_NSMP_HI       2
`define PMC_NSMP_LO       0
`define PMC_SETUP_RST     16'hfb68

// Start setup fields
`define PMC_DLY_HI        13
`define PMC_DLY_LO        6
`define PMC_DLY_RST       8'h00

// Status fields
`define PMC_ST_READY      1
`define PMC_ST_BUSY       0

// Timing
`define PMC_CLK_MHZ       250
`define PMC_DLY_STEP_US   2000
`define PMC_CT_US_0       50
`define PMC_CT_US_1       84
`define PMC_CT_US_2       150
`define PMC_CT_US_3       280
`define PMC_CT_US_4       540
`define PMC_CT_US_5       1052
`define PMC_CT_US_6       2074
`define PMC_CT_US_7       4120

// Power scaling: bus LSB times current LSB times 64 is one power LSB
`define PMC_PWR_SHIFT     6

`endif

// >>> pmc_conv_timer.sv
/*
 * Down counter that times one conversion or start delay.
 * Assumes load is a one-cycle pulse and load_val is at least one.
 */
`timescale 1ns/1ps
`default_nettype none

module pmc_conv_timer (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Load
	input  wire logic        load,
	input  wire logic [31:0] load_val,
	// Expiry pulse, load_val + 1 cycles after load
	output logic             done
);

	pmc_pkg::pmc_tmr_state_t s_r;
	pmc_pkg::pmc_tmr_state_t s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.done = 1'b0;
		if (load) begin
			s_nxt.cnt = load_val;
			s_nxt.run = 1'b1;
		end else if (s_r.run) begin
			if (s_r.cnt <= 32'h0000_0001) begin
				s_nxt.run  = 1'b0;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign done = s_r.done;

endmodule // pmc_conv_timer

`default_nettype wire

// >>> pmc_pkg.sv
/*
 * Types of the converter control block: sequencer states, register selects, state records.
 * Assumes the constants header is compiled alongside.
 */
`default_nettype none

package pmc_pkg;

	typedef enum logic [6:0] {
		S_IDLE  = 7'b000_0001,
		S_DELAY = 7'b000_0010,
		S_TEMP  = 7'b000_0100,
		S_CURR  = 7'b000_1000,
		S_BUS   = 7'b001_0000,
		S_STORE = 7'b010_0000,
		S_PWR   = 7'b100_0000
	} pmc_state_t;

	typedef enum logic [2:0] {
		R_NONE, R_START, R_SETUP, R_STATUS, R_BUS, R_TEMP, R_CURR, R_POWER
	} pmc_reg_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic        run;
		logic        done;
	} pmc_tmr_state_t;

	typedef struct packed {
		pmc_state_t  st;
		logic        armed;
		logic [10:0] rnd;
		logic [27:0] acc_bus;
		logic [27:0] acc_tmp;
		logic [27:0] acc_cur;
		logic [15:0] bus_res;
		logic [11:0] tmp_res;
		logic [15:0] cur_res;
		logic [23:0] pwr_res;
		logic [15:0] setup;
		logic [7:0]  dly;
		logic        ready;
		logic        tld;
		logic [31:0] tval;
		logic [2:0]  chan;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pmc_state_rec_t;

endpackage

`default_nettype wire

// >>> tb.sv
/*
 * Self-checking testbench of the converter control block.
 * Assumes zero wait APB slave and times shortened to one cycle per microsecond.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] x;
		logic        e;
	} pmc_tb_row_t;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, conv_ready;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] bus_sample, current_sample;
	logic [11:0] temp_sample;
	logic [2:0]  chan_sel;
	int          n_mismatch, n_checks, i, k, nt, nc, nb;

	localparam pmc_tb_row_t ROWS[15] = '{
		'{1'b0, 8'h04, 32'h0, 32'h0000_fb68, 1'b0},
		'{1'b0, 8'h14, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h18, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h1c, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h20, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h0c, 32'h0, 32'h0, 1'b1},
		'{1'b0, 8'h06, 32'h0, 32'h0, 1'b1},
		'{1'b1, 8'h14, 32'hffff_ffff, 32'h0, 1'b0},
		'{1'b0, 8'h14, 32'h0, 32'h0, 1'b0},
		'{1'b1, 8'h00, 32'hffff_ffff, 32'h0, 1'b0},
		'{1'b0, 8'h00, 32'h0, 32'h0000_3fc0, 1'b0},
		'{1'b1, 8'h00, 32'h0, 32'h0, 1'b0},
		'{1'b1, 8'h04, 32'hffff_0fff, 32'h0, 1'b0},
		'{1'b0, 8'h04, 32'h0, 32'h0000_0fff, 1'b0}
	};
	localparam logic [3:0] MODES[12] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7,
		4'h8, 4'h9, 4'hc, 4'hd, 4'hf, 4'he};
	localparam logic [2:0] FIRST[12] = '{3'h0, 3'h1, 3'h4, 3'h4, 3'h4, 3'h4,
		3'h0, 3'h1, 3'h4, 3'h4, 3'h4, 3'h0};

	pmc_adc_ctrl #(.CYC_PER_US(1)) u_pmc_adc_ctrl (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_sample(bus_sample), .current_sample(current_sample), .temp_sample(temp_sample),
		.chan_sel(chan_sel), .conv_ready(conv_ready));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic final_report;
		$display("Checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 50) begin
				n_mismatch++;
				final_report();
			end
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
	endtask

	// Waits for the ready flag, counting cycles per channel
	task automatic wready(input int lim);
		nt = 0;
		nc = 0;
		nb = 0;
		i = 0;
		while (conv_ready !== 1'b1) begin
			@(posedge pclk);
			nt += int'(chan_sel === 3'h4);
			nc += int'(chan_sel === 3'h2);
			nb += int'(chan_sel === 3'h1);
			i++;
			if (i > lim) begin
				n_mismatch++;
				final_report();
			end
		end
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		bus_sample = 16'h0640;
		current_sample = 16'hff00;
		temp_sample = 12'h0c8;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ROWS[r]) begin
			apb(ROWS[r].w, ROWS[r].a, ROWS[r].d, q, e);
			if (!ROWS[r].w)
				chk(q, ROWS[r].x);
			chk({31'h0, e}, {31'h0, ROWS[r].e});
		end
		// Legal mode codes and the undefined Eh, first channel of each
		for (k = 0; k < 12; k++) begin
			apb(1'b1, 8'h04, {16'h0, MODES[k], 12'h000}, q, e);
			rdchk(8'h04, {16'h0, MODES[k], 12'h000});
			repeat (5) @(posedge pclk);
			chk({29'h0, chan_sel}, {29'h0, FIRST[k]});
		end
		// Triggered full sequence, distinct times
		rdchk(8'h08, 32'h0);
		apb(1'b1, 8'h04, 32'h0000_7440, q, e);
		wready(2000);
		chk(nc - nt, 84);
		chk(nb - nt, 100);
		k = nt;
		rdchk(8'h14, 32'h0000_0640);
		rdchk(8'h18, 32'h0000_0c80);
		rdchk(8'h1c, 32'h0000_ff00);
		rdchk(8'h20, 32'h0000_1900);
		rdchk(8'h08, 32'h0000_0002);
		nb = 0;
		repeat (300) begin
			@(posedge pclk);
			nb += int'(chan_sel !== 3'h0);
		end
		chk(nb, 0);
		chk({31'h0, conv_ready}, 32'h0);
		// Averaging over four rounds, then a second run counted whole
		temp_sample <= 12'h010;
		apb(1'b1, 8'h04, 32'h0000_4001, q, e);
		repeat (120) @(posedge pclk);
		rdchk(8'h18, 32'h0000_0c80);
		wready(1000);
		rdchk(8'h18, 32'h0000_0100);
		rdchk(8'h08, 32'h0000_0002);
		apb(1'b1, 8'h04, 32'h0000_4001, q, e);
		wready(1000);
		chk(nt, 4 * k);
		// Start delay of one step
		apb(1'b1, 8'h00, 32'h0000_0040, q, e);
		apb(1'b1, 8'h04, 32'h0000_4000, q, e);
		repeat (1000) @(posedge pclk);
		chk({29'h0, chan_sel}, 32'h0);
		repeat (1020) @(posedge pclk);
		chk({29'h0, chan_sel}, 32'h4);
		final_report();
	end
endmodule // tb

`default_nettype wire
